// >>> design/spl_shift_latch.sv
// top: serial-in parallel-out shift register with storage latch

module spl_shift_latch #(
  parameter int WIDTH = spl_pkg::SPL_WIDTH
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // host pins
  input  wire logic                 serial_in,
  input  wire logic                 shift_clock,
  input  wire logic                 store_clock,
  input  wire logic                 shift_clear_n,
  input  wire logic                 output_enable_n,
  // parallel outputs, bit 0 is qa
  output logic      [WIDTH-1:0]     parallel_outputs,
  output logic      [WIDTH-1:0]     parallel_outputs_oe,
  // cascade
  output logic                      cascade_out
);
  import spl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pin_sync;
  logic       ser_s, sclk_s, rclk_s, clr_n_s, oe_n_s;

  // pins read as idle until synced, so outputs stay off after reset
  spl_sync #(.WIDTH(5), .RESET_VAL(SPL_PIN_IDLE)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({serial_in, shift_clock, store_clock,
                shift_clear_n, output_enable_n}),
    .sync_out (pin_sync)
  );

  assign {ser_s, sclk_s, rclk_s, clr_n_s, oe_n_s} = pin_sync;

  ////////////////////////////////////////////////////////////////////////
  // edge detection
  logic sclk_d_reg, sclk_d_next;
  logic rclk_d_reg, rclk_d_next;
  logic sclk_rise, rclk_rise;

  always_comb begin
    sclk_d_next = sclk_s;
    rclk_d_next = rclk_s;
    sclk_rise   = sclk_s && !sclk_d_reg;
    rclk_rise   = rclk_s && !rclk_d_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d_reg <= 1'b0;
      rclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_d_next;
      rclk_d_reg <= rclk_d_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift chain
  logic [WIDTH-1:0] chain_reg, chain_next;
  logic [WIDTH-1:0] chain_shifted;

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_stage
      if (i == 0) begin : g_first
        assign chain_shifted[i] = ser_s;
      end else begin : g_rest
        assign chain_shifted[i] = chain_reg[i-1];
      end
    end
  endgenerate

  always_comb begin
    chain_next = chain_reg;
    if (!clr_n_s) begin
      chain_next = SPL_CLEAR_VAL[WIDTH-1:0];
    end else if (sclk_rise) begin
      chain_next = chain_shifted;
    end
  end

  // the reset value only stands in for an undefined start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event decode: previous cycle's pin event and the chain before the last shift
  // synchroniser skew may split tied clock edges by one cycle, so a
  // store seen one cycle after a shift still takes the pre-shift chain
  spl_op_t          op_reg, op_next;
  logic [WIDTH-1:0] chain_prev_reg, chain_prev_next;
  logic [WIDTH-1:0] snap_word;

  always_comb begin
    op_next         = SPL_IDLE;
    chain_prev_next = chain_prev_reg;
    if (clr_n_s && sclk_rise) begin
      op_next         = SPL_SHIFT;
      chain_prev_next = chain_reg;
    end else if (rclk_rise) begin
      op_next = SPL_STORE;
    end
  end

  // store within one cycle of a shift counts as tied
  always_comb begin
    case (op_reg)
      SPL_SHIFT: begin
        snap_word = chain_prev_reg;
      end
      SPL_IDLE,
      SPL_STORE: begin
        snap_word = chain_reg;
      end
      default: begin
        snap_word = chain_reg;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_reg         <= SPL_IDLE;
      chain_prev_reg <= '0;
    end else begin
      op_reg         <= op_next;
      chain_prev_reg <= chain_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // store path through the two-entry buffer
  spl_word_if w_in ();
  spl_word_if w_out ();

  // snapshot is the old chain, so tied clocks lag by one
  assign w_in.word  = snap_word;
  assign w_in.valid = rclk_rise;
  assign w_out.ready = 1'b1;

  spl_word_buf #(.DEPTH(SPL_BUF_DEPTH)) u_buf (
    .clk     (clk),
    .reset_n (reset_n),
    .in_p    (w_in),
    .out_p   (w_out)
  );

  logic [WIDTH-1:0] store_reg, store_next;

  always_comb begin
    store_next = store_reg;
    if (w_out.valid) begin
      store_next = w_out.word;
    end
  end

  // clear leaves storage alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      store_reg <= '0;
    end else begin
      store_reg <= store_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output drivers
  logic [WIDTH-1:0] po_next, oe_next;
  logic             casc_next;

  always_comb begin
    po_next   = oe_n_s ? SPL_OUT_OFF[WIDTH-1:0] : store_next;
    oe_next   = {WIDTH{!oe_n_s}};
    casc_next = chain_next[WIDTH-1];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      parallel_outputs    <= '0;
      parallel_outputs_oe <= '0;
      cascade_out         <= 1'b0;
    end else begin
      parallel_outputs    <= po_next;
      parallel_outputs_oe <= oe_next;
      cascade_out         <= casc_next;
    end
  end
endmodule

// >>> design/spl_pkg.sv
// package: widths, pin sync depth and state encodings for the shift latch
package spl_pkg;
  localparam int SPL_WIDTH      = 8;
  localparam int SPL_SYNC_DEPTH = 2;
  localparam int SPL_BUF_DEPTH  = 2;
  localparam logic [7:0] SPL_CLEAR_VAL = 8'h00;
  localparam logic [7:0] SPL_OUT_OFF   = 8'h00;
  // pin reset levels {ser, sclk, rclk, clr_n, oe_n}: clear and enable idle
  localparam logic [4:0] SPL_PIN_IDLE  = 5'h03;
  typedef logic [SPL_WIDTH-1:0] spl_word_t;
  typedef enum logic [1:0] {SPL_IDLE, SPL_SHIFT, SPL_STORE} spl_op_t;
endpackage

// >>> design/spl_word_if.sv
// interface: word stream between shift front end and storage side
interface spl_word_if;
  import spl_pkg::*;
  spl_word_t word;
  logic      valid;
  logic      ready;
  modport src (output word, output valid, input ready);
  modport dst (input word, input valid, output ready);
endinterface

// >>> design/spl_word_buf.sv
// two-entry buffer with valid and ready on both sides
module spl_word_buf #(
  parameter int DEPTH = spl_pkg::SPL_BUF_DEPTH
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // ports
  spl_word_if.dst   in_p,
  spl_word_if.src   out_p
);
  import spl_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  spl_word_t        mem_reg [DEPTH];
  spl_word_t        mem_next [DEPTH];
  logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign in_p.ready  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_p.valid = (cnt_reg != '0);
  assign out_p.word  = mem_reg[rd_reg];

  always_comb begin
    push = in_p.valid && in_p.ready;
    pop  = out_p.valid && out_p.ready;
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_p.word;
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - (PW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// >>> design/spl_sync.sv
// two-flop synchroniser per bit
module spl_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_out <= sync_next;
    end
  end
endmodule

// >>> test/spl_shift_latch_checker.sv
// checker: pin-level timing relations of the shift latch
module spl_shift_latch_checker #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             reset_n,
  // host pins
  input wire logic             serial_in,
  input wire logic             shift_clock,
  input wire logic             store_clock,
  input wire logic             shift_clear_n,
  input wire logic             output_enable_n,
  // outputs
  input wire logic [WIDTH-1:0] parallel_outputs,
  input wire logic [WIDTH-1:0] parallel_outputs_oe,
  input wire logic             cascade_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  oe_off_a: assert property (
    output_enable_n [*5] |-> parallel_outputs_oe == '0)
    else $error("outputs driven while disabled");
  oe_on_a: assert property (
    !output_enable_n [*5] |-> parallel_outputs_oe == '1)
    else $error("outputs not driven while enabled");
  oe_whole_a: assert property (
    parallel_outputs_oe == '0 || parallel_outputs_oe == '1)
    else $error("output enables split");
  float_zero_a: assert property (
    parallel_outputs_oe == '0 |-> parallel_outputs == '0)
    else $error("floating outputs carry data");
  clear_chain_a: assert property (
    !shift_clear_n [*5] |-> !cascade_out)
    else $error("cascade not cleared");
  shift_low_a: assert property (
    (shift_clear_n && !shift_clock) [*5] |-> $stable(cascade_out))
    else $error("cascade moved without rising edge");
  shift_high_a: assert property (
    (shift_clear_n && shift_clock) [*6] |-> $stable(cascade_out))
    else $error("cascade moved on steady high");
  store_hold_a: assert property (
    (!store_clock && !output_enable_n) [*6] |-> $stable(parallel_outputs))
    else $error("storage moved without store edge");
  cover property (parallel_outputs_oe == '1 && parallel_outputs != '0);
  cover property ($rose(cascade_out));
  cover property (!shift_clear_n [*5]);
endmodule

bind spl_shift_latch spl_shift_latch_checker #(.WIDTH(WIDTH)) i_chk (
  .clk, .reset_n, .serial_in, .shift_clock, .store_clock, .shift_clear_n,
  .output_enable_n, .parallel_outputs, .parallel_outputs_oe, .cascade_out);

// >>> test/spl_host.sv
// host model: drives the latch pins as a controller would
module spl_host (
  // clock
  input  wire logic clk,
  // pins
  output logic      serial_in,
  output logic      shift_clock,
  output logic      store_clock,
  output logic      shift_clear_n,
  output logic      output_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_in = 1'b0;
    shift_clock = 1'b0;
    store_clock = 1'b0;
    shift_clear_n = 1'b0;
    output_enable_n = 1'b1;
  end
  ////////////////////////////////////////
  task automatic step(logic sh, logic st, logic d);
    @(posedge clk);
    shift_clock <= sh;
    store_clock <= st;
    serial_in <= d;
    repeat (5) @(posedge clk);
  endtask
  task automatic pulse(logic sh, logic st, logic d);
    step(1'b0, 1'b0, d);
    step(sh, st, d);
  endtask
  task automatic load(logic [7:0] b);
    for (int i = 7; i >= 0; i--) pulse(1'b1, 1'b0, b[i]);
    pulse(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b0);
  endtask
  task automatic ctl(logic clr_n, logic oe_n);
    @(posedge clk);
    shift_clear_n <= clr_n;
    output_enable_n <= oe_n;
    repeat (5) @(posedge clk);
  endtask
endmodule

// >>> test/spl_shift_latch_tb_top.sv
// bench top: host model drives the shift latch, tasks judge outputs
module spl_shift_latch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spl_pkg::*;
  logic      clk;
  logic      reset_n;
  logic      serial_in;
  logic      shift_clock;
  logic      store_clock;
  logic      shift_clear_n;
  logic      output_enable_n;
  spl_word_t parallel_outputs;
  spl_word_t parallel_outputs_oe;
  logic      cascade_out;
  int        mismatches = 0;
  int        cmp_count = 0;
  int        cycles = 0;
  spl_host i_host (.clk, .serial_in, .shift_clock, .store_clock,
    .shift_clear_n, .output_enable_n);
  spl_shift_latch i_dut (.clk, .reset_n, .serial_in, .shift_clock,
    .store_clock, .shift_clear_n, .output_enable_n, .parallel_outputs,
    .parallel_outputs_oe, .cascade_out);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic chk(string name, spl_word_t seen, spl_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_load(spl_word_t b);
    i_host.load(b);
    chk("word", parallel_outputs, b);
    chk("cascade", {7'h00, cascade_out}, {7'h00, b[7]});
  endtask
  task automatic t_disable(spl_word_t b);
    i_host.ctl(1'b1, 1'b1);
    chk("oe off", parallel_outputs_oe, 8'h00);
    chk("off data", parallel_outputs, SPL_OUT_OFF);
    chk("ungated", {7'h00, cascade_out}, {7'h00, b[7]});
    i_host.ctl(1'b1, 1'b0);
    chk("oe on", parallel_outputs_oe, 8'hFF);
  endtask
  task automatic t_clear(spl_word_t b);
    i_host.ctl(1'b0, 1'b0);
    i_host.pulse(1'b1, 1'b0, 1'b1);
    chk("clr cascade", {7'h00, cascade_out}, 8'h00);
    chk("clr keeps", parallel_outputs, b);
    i_host.ctl(1'b1, 1'b0);
    i_host.pulse(1'b0, 1'b1, 1'b0);
    i_host.step(1'b0, 1'b0, 1'b0);
    chk("clr stored", parallel_outputs, 8'h00);
  endtask
  task automatic t_tied();
    i_host.load(8'hFF);
    i_host.pulse(1'b1, 1'b1, 1'b0);
    i_host.step(1'b0, 1'b0, 1'b0);
    chk("tied lag", parallel_outputs, 8'hFF);
    i_host.pulse(1'b0, 1'b1, 1'b0);
    i_host.step(1'b0, 1'b0, 1'b0);
    chk("tied next", parallel_outputs, 8'hFE);
  endtask
  initial begin
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    i_host.ctl(1'b1, 1'b0);
    t_load(8'h3C);
    t_load(8'hA5);
    t_disable(8'hA5);
    t_clear(8'hA5);
    t_tied();
    give_verdict();
  end
endmodule
